// ===== rtl/cnc_clock_network.sv
`timescale 1ns/10ps
`default_nettype none
`include "cnc_defs.svh"

// Contract
// - One independent control block per global and regional network
// - Only global blocks accept a select that changes at run time
// - Regional source choice comes only from static configuration bits
// - Two-bit global select picks inputs: 0,1 pins; 2,3 PLL outputs
// - Inputs 0 and 1 route from any of four same-side pins
// - Input 2 fed by counter zero or two of two PLLs
// - Input 3 fed by counter one or three of two PLLs
// - Only counters zero to three reach global networks on that variant
// - Left-side variant: input 0 counter four/six, input 1 counter five
// - Core enable powers networks up or down, applied synchronously
// - Gating sits on network after selection, independent of PLLs
// - Disabled network holds its clock inactive, no edges
// - Unused networks held off by static configuration bit
// - Dynamic select ignored before user mode
// - External output select fixed by configuration in user mode
// - Pin output cell muxes core signal or control block output
// - Enable taken while clock low; no shortened pulse
// - Extra enable register, bypassable by configuration except on external pins

module cnc_clock_network #(
  parameter int GLOBAL_N = 16,
  parameter int REGIONAL_N = 48,
  parameter int EXT_N = 2,
  parameter bit LEFT_ONLY_PLL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Configuration state
  input wire logic userModePin,
  input wire cnc_pkg::cnc_sel_t cfgPinPickA,
  input wire cnc_pkg::cnc_sel_t cfgPinPickB,
  input wire logic cfgPllEven,
  input wire logic cfgCntEven,
  input wire logic cfgPllOdd,
  input wire logic cfgCntOdd,
  input wire logic cfgPllLeft,
  input wire logic cfgCntLeft,
  input wire logic [GLOBAL_N-1:0] cfgGlobalOff,
  input wire logic [GLOBAL_N-1:0] cfgGlobalBypass,
  input wire cnc_pkg::cnc_sel_t [REGIONAL_N-1:0] cfgRegionalSel,
  input wire logic [REGIONAL_N-1:0] cfgRegionalOff,
  input wire logic [REGIONAL_N-1:0] cfgRegionalBypass,
  input wire cnc_pkg::cnc_sel_t [EXT_N-1:0] cfgExtSel,
  input wire logic [EXT_N-1:0] cfgExtOff,
  input wire logic [EXT_N-1:0] cfgExtDrive,
  // Source clocks
  input wire logic [`CNC_PIN_N-1:0] pinClk,
  input wire logic [`CNC_PLL_N*`CNC_CNT_N-1:0] pllCnt,
  // Core logic
  input wire cnc_pkg::cnc_sel_t [GLOBAL_N-1:0] sourceSelect,
  input wire logic [GLOBAL_N-1:0] globalEna,
  input wire logic [REGIONAL_N-1:0] regionalEna,
  input wire logic [EXT_N-1:0] extEna,
  input wire logic [EXT_N-1:0] extCoreData,
  // Networks and pins
  output logic [GLOBAL_N-1:0] globalNet,
  output logic [REGIONAL_N-1:0] regionalNet,
  output logic [EXT_N-1:0] extPllClkPin,
  output logic userMode
);

  import cnc_pkg::*;

  localparam int PLL_BITS = `CNC_PLL_N * `CNC_CNT_N;
  localparam int SRC_N = `CNC_PIN_N + PLL_BITS + 1;

  logic [SRC_N-1:0] rawIn;
  logic [SRC_N-1:0] syncIn;
  logic [`CNC_PIN_N-1:0] pinS;
  logic [PLL_BITS-1:0] pllS;
  logic [3:0] inclk;

  cnc_sel_t pinPickA_r;
  cnc_sel_t pinPickB_r;
  logic pllEven_r;
  logic cntEven_r;
  logic pllOdd_r;
  logic cntOdd_r;
  logic pllLeft_r;
  logic cntLeft_r;
  logic [GLOBAL_N-1:0] globalOff_r;
  logic [GLOBAL_N-1:0] globalBypass_r;
  cnc_sel_t [REGIONAL_N-1:0] regionalSel_r;
  logic [REGIONAL_N-1:0] regionalOff_r;
  logic [REGIONAL_N-1:0] regionalBypass_r;
  cnc_sel_t [EXT_N-1:0] extSel_r;
  logic [EXT_N-1:0] extOff_r;
  logic [EXT_N-1:0] extDrive_r;
  logic [EXT_N-1:0] extGated;
  logic [EXT_N-1:0] extPin_r;

  // Four-way source pick
  function automatic logic pick4(input logic [3:0] src, input cnc_sel_t sel);
    pick4 = src[sel];
  endfunction

  // Flat position of one PLL counter
  function automatic logic [`CNC_IDX_W-1:0] cntIdx(input logic pll, input cnc_cnt_t cnt);
    logic [`CNC_IDX_W-1:0] base;
    base = pll ? `CNC_IDX_W'(`CNC_CNT_N) : '0;
    cntIdx = base + `CNC_IDX_W'(cnt);
  endfunction

  // Pins, counters and mode strap from outside
  assign rawIn = {userModePin, pllCnt, pinClk};

  cnc_sync #(
    .WIDTH(SRC_N)
  ) uSync (
    .clk(clk),
    .reset_n(reset_n),
    .asyncIn(rawIn),
    .syncOut(syncIn)
  );

  assign pinS = syncIn[`CNC_PIN_N-1:0];
  assign pllS = syncIn[`CNC_PIN_N +: PLL_BITS];
  assign userMode = syncIn[SRC_N-1];

  // Routing bits loaded before user mode, frozen after
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pinPickA_r <= `CNC_PICK_RST;
      pinPickB_r <= `CNC_PICK_RST;
      pllEven_r <= `CNC_BIT_RST;
      cntEven_r <= `CNC_BIT_RST;
      pllOdd_r <= `CNC_BIT_RST;
      cntOdd_r <= `CNC_BIT_RST;
      pllLeft_r <= `CNC_BIT_RST;
      cntLeft_r <= `CNC_BIT_RST;
    end
    else if (!userMode)
    begin
      pinPickA_r <= cfgPinPickA;
      pinPickB_r <= cfgPinPickB;
      pllEven_r <= cfgPllEven;
      cntEven_r <= cfgCntEven;
      pllOdd_r <= cfgPllOdd;
      cntOdd_r <= cfgCntOdd;
      pllLeft_r <= cfgPllLeft;
      cntLeft_r <= cfgCntLeft;
    end
  end

  // Per-network static bits; unused networks stay dark
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      globalOff_r <= '1;
      globalBypass_r <= '0;
      regionalSel_r <= '0;
      regionalOff_r <= '1;
      regionalBypass_r <= '0;
      extSel_r <= '0;
      extOff_r <= '1;
      extDrive_r <= '0;
    end
    else if (!userMode)
    begin
      globalOff_r <= cfgGlobalOff;
      globalBypass_r <= cfgGlobalBypass;
      regionalSel_r <= cfgRegionalSel;
      regionalOff_r <= cfgRegionalOff;
      regionalBypass_r <= cfgRegionalBypass;
      extSel_r <= cfgExtSel;
      extOff_r <= cfgExtOff;
      extDrive_r <= cfgExtDrive;
    end
  end

  // Shared source inputs of this side
  always_comb
  begin
    if (LEFT_ONLY_PLL)
    begin
      inclk[0] = pllS[cntIdx(pllLeft_r, cntLeft_r ? `CNC_CNT_SIX : `CNC_CNT_FOUR)];
      inclk[1] = pllS[cntIdx(pllLeft_r, `CNC_CNT_FIVE)];
    end
    else
    begin
      inclk[0] = pinS[pinPickA_r];
      inclk[1] = pinS[pinPickB_r];
    end
    inclk[2] = pllS[cntIdx(pllEven_r, cntEven_r ? `CNC_CNT_TWO : `CNC_CNT_ZERO)];
    inclk[3] = pllS[cntIdx(pllOdd_r, cntOdd_r ? `CNC_CNT_THREE : `CNC_CNT_ONE)];
  end

  // Global networks with run-time select
  for (genvar g = 0; g < GLOBAL_N; g++)
  begin : gGlobal
    cnc_sw_e swState_r;
    cnc_sel_t activeSel_r;
    cnc_sel_t pendSel_r;
    logic muxOut;

    // Switch only between low phases of old and new source
    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        swState_r <= SW_RUN;
        activeSel_r <= `CNC_SEL_RST;
        pendSel_r <= `CNC_SEL_RST;
      end
      else
      begin
        case (swState_r)
          SW_RUN:
            if (userMode && sourceSelect[g] != activeSel_r)
            begin
              pendSel_r <= sourceSelect[g];
              swState_r <= SW_DRAIN;
            end
          SW_DRAIN:
            if (!pick4(inclk, activeSel_r))
              swState_r <= SW_ARM;
          SW_ARM:
            if (!pick4(inclk, pendSel_r))
            begin
              activeSel_r <= pendSel_r;
              swState_r <= SW_RUN;
            end
          default:
            swState_r <= SW_RUN;
        endcase
      end
    end

    assign muxOut = (swState_r == SW_ARM) ? 1'b0 : pick4(inclk, activeSel_r);

    cnc_gate #(
      .HAS_BYPASS(1'b1)
    ) uGate (
      .clk(clk),
      .reset_n(reset_n),
      .srcClk(muxOut),
      .enaIn(globalEna[g]),
      .bypassMeta(globalBypass_r[g]),
      .staticOff(globalOff_r[g]),
      .netClk(globalNet[g])
    );

    chk_sel_hold: assert property (
      @(posedge clk) disable iff (!reset_n)
      (!userMode && swState_r == SW_RUN) |=> (swState_r == SW_RUN && $stable(activeSel_r)))
      else $error("Select moved before user mode");

    chk_switch_low: assert property (
      @(posedge clk) disable iff (!reset_n)
      (activeSel_r != $past(activeSel_r)) |->
        ($past(swState_r) == SW_ARM && !$past(inclk[pendSel_r])))
      else $error("Source switched while new source high");

    chk_sel_idle: assert property (
      @(posedge clk) disable iff (!reset_n)
      !userMode |-> (activeSel_r == `CNC_SEL_RST))
      else $error("Global select left default before user mode");

    chk_pend_wait: assert property (
      @(posedge clk) disable iff (!reset_n)
      (swState_r != SW_RUN) |=> $stable(pendSel_r))
      else $error("Pending select moved during a switch");
  end

  // Regional networks with static select only
  for (genvar r = 0; r < REGIONAL_N; r++)
  begin : gRegional
    cnc_gate #(
      .HAS_BYPASS(1'b1)
    ) uGate (
      .clk(clk),
      .reset_n(reset_n),
      .srcClk(pick4(inclk, regionalSel_r[r])),
      .enaIn(regionalEna[r]),
      .bypassMeta(regionalBypass_r[r]),
      .staticOff(regionalOff_r[r]),
      .netClk(regionalNet[r])
    );

    chk_regional_dark: assert property (
      @(posedge clk) disable iff (!reset_n)
      regionalOff_r[r] ##1 regionalOff_r[r] |-> !regionalNet[r])
      else $error("Unused regional network produced a clock level");
  end

  // External PLL clock pins
  for (genvar e = 0; e < EXT_N; e++)
  begin : gExt
    cnc_gate #(
      .HAS_BYPASS(1'b0)
    ) uGate (
      .clk(clk),
      .reset_n(reset_n),
      .srcClk(pick4(inclk, extSel_r[e])),
      .enaIn(extEna[e]),
      .bypassMeta(1'b0),
      .staticOff(extOff_r[e]),
      .netClk(extGated[e])
    );

    // Pin output cell multiplexer
    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
        extPin_r[e] <= 1'b0;
      else
        extPin_r[e] <= extDrive_r[e] ? extGated[e] : extCoreData[e];
    end

    chk_pin_cell: assert property (
      @(posedge clk) disable iff (!reset_n)
      ($past(reset_n) && !$past(extDrive_r[e])) |-> (extPin_r[e] == $past(extCoreData[e])))
      else $error("Pin cell ignored core signal");

    chk_pin_clock: assert property (
      @(posedge clk) disable iff (!reset_n)
      ($past(reset_n) && $past(extDrive_r[e])) |-> (extPin_r[e] == $past(extGated[e])))
      else $error("Pin cell ignored gated clock");
  end

  assign extPllClkPin = extPin_r;

  chk_cfg_frozen: assert property (
    @(posedge clk) disable iff (!reset_n)
    (userMode && $past(userMode)) |-> ($stable(extSel_r) && $stable(regionalSel_r)))
    else $error("Static select changed in user mode");

  chk_route_frozen: assert property (
    @(posedge clk) disable iff (!reset_n)
    (userMode && $past(userMode)) |-> ($stable(pinPickA_r) && $stable(regionalOff_r)))
    else $error("Routing changed in user mode");

endmodule

`default_nettype wire

// ===== rtl/cnc_defs.svh
`ifndef CNC_DEFS_SVH
`define CNC_DEFS_SVH

// Source routing sizes
`define CNC_SEL_W 2
`define CNC_PIN_N 4
`define CNC_PLL_N 2
`define CNC_CNT_N 7
`define CNC_IDX_W 4

// Counter positions inside one PLL
`define CNC_CNT_ZERO 3'h0
`define CNC_CNT_ONE 3'h1
`define CNC_CNT_TWO 3'h2
`define CNC_CNT_THREE 3'h3
`define CNC_CNT_FOUR 3'h4
`define CNC_CNT_FIVE 3'h5
`define CNC_CNT_SIX 3'h6

// Reset values
`define CNC_SEL_RST 2'h0
`define CNC_PICK_RST 2'h0
`define CNC_BIT_RST 1'b0

`endif

// ===== rtl/cnc_gate.sv
`timescale 1ns/10ps
`default_nettype none

module cnc_gate #(
  parameter bit HAS_BYPASS = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Selected source level
  input wire logic srcClk,
  // Enable control
  input wire logic enaIn,
  input wire logic bypassMeta,
  input wire logic staticOff,
  // Gated network
  output logic netClk
);

  logic meta_r;
  logic ena_r;
  logic net_r;
  logic enaPick;

  // Extra register for asynchronous enables
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      meta_r <= 1'b0;
    else
      meta_r <= enaIn;
  end

  assign enaPick = (HAS_BYPASS && bypassMeta) ? enaIn : meta_r;

  // Enable taken only while the clock is low
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ena_r <= 1'b0;
    else if (!srcClk)
      ena_r <= enaPick && !staticOff;
  end

  // Gate after selection
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      net_r <= 1'b0;
    else
      net_r <= srcClk && ena_r && !staticOff;
  end

  assign netClk = net_r;

  chk_ena_low_only: assert property (
    @(posedge clk) disable iff (!reset_n)
    (ena_r != $past(ena_r)) |-> !$past(srcClk))
    else $error("Enable changed while source was high");

  chk_off_silent: assert property (
    @(posedge clk) disable iff (!reset_n)
    staticOff ##1 staticOff |-> !net_r)
    else $error("Disabled network produced a clock level");

  chk_no_short: assert property (
    @(posedge clk) disable iff (!reset_n)
    $fell(net_r) |-> (!$past(srcClk) || $past(staticOff)))
    else $error("Network pulse cut short");

endmodule

`default_nettype wire

// ===== rtl/cnc_pkg.sv
package cnc_pkg;

  typedef logic [1:0] cnc_sel_t;

  typedef logic [2:0] cnc_cnt_t;

  typedef enum logic [1:0] {SW_RUN, SW_DRAIN, SW_ARM} cnc_sw_e;

endpackage

// ===== rtl/cnc_sync.sv
`timescale 1ns/10ps
`default_nettype none

module cnc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Levels from outside the clock domain
  input wire logic [WIDTH-1:0] asyncIn,
  // Filtered levels
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stageA_r;
  logic [WIDTH-1:0] stageB_r;
  logic [WIDTH-1:0] stageC_r;
  logic [WIDTH-1:0] level_r;

  // Three stage chain
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stageA_r <= '0;
      stageB_r <= '0;
      stageC_r <= '0;
    end
    else
    begin
      stageA_r <= asyncIn;
      stageB_r <= stageA_r;
      stageC_r <= stageB_r;
    end
  end

  // Change counts once second and third agree
  for (genvar i = 0; i < WIDTH; i++)
  begin : gBit
    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
        level_r[i] <= 1'b0;
      else if (stageB_r[i] == stageC_r[i])
        level_r[i] <= stageC_r[i];
    end
  end

  assign syncOut = level_r;

endmodule

`default_nettype wire

// ===== sim/cnc_clock_network_tb.sv
`timescale 1ns/10ps
`default_nettype none

module cnc_clock_network_tb;
  import cnc_pkg::*;
  logic clk;
  logic reset_n;
  logic userModePin;
  cnc_sel_t cfgPinPickA;
  cnc_sel_t cfgPinPickB;
  logic cfgPllEven;
  logic cfgCntEven;
  logic cfgPllOdd;
  logic cfgCntOdd;
  logic cfgGlobalOff;
  logic cfgGlobalBypass;
  cnc_sel_t cfgRegionalSel;
  cnc_sel_t cfgExtSel;
  logic cfgRegionalOff, cfgRegionalBypass, cfgExtOff;
  logic cfgExtDrive;
  logic extCoreData;
  logic [3:0] pinClk;
  logic [13:0] pllCnt;
  cnc_sel_t sourceSelect;
  logic [2:0] enaBits;
  logic [2:0] ena;
  logic globalNet;
  logic regionalNet;
  logic extPllClkPin;
  logic userMode;
  logic [1:0] probeSel;
  logic probe;
  logic [7:0] edges;
  int failures;
  int checkCount;
  int cycles;

  cnc_core_model cnc_core_model_i (.clk(clk), .reset_n(reset_n), .pinClk(pinClk),
    .pllCnt(pllCnt), .sourceSelect(sourceSelect), .enaBits(enaBits));

  cnc_clock_network #(.GLOBAL_N(1), .REGIONAL_N(1), .EXT_N(1)) cnc_clock_network_i (
    .clk(clk), .reset_n(reset_n), .userModePin(userModePin),
    .cfgPinPickA(cfgPinPickA), .cfgPinPickB(cfgPinPickB),
    .cfgPllEven(cfgPllEven), .cfgCntEven(cfgCntEven),
    .cfgPllOdd(cfgPllOdd), .cfgCntOdd(cfgCntOdd),
    .cfgPllLeft(1'b0), .cfgCntLeft(1'b0),
    .cfgGlobalOff(cfgGlobalOff), .cfgGlobalBypass(cfgGlobalBypass),
    .cfgRegionalSel(cfgRegionalSel), .cfgRegionalOff(cfgRegionalOff),
    .cfgRegionalBypass(cfgRegionalBypass),
    .cfgExtSel(cfgExtSel), .cfgExtOff(cfgExtOff), .cfgExtDrive(cfgExtDrive),
    .pinClk(pinClk), .pllCnt(pllCnt), .sourceSelect(sourceSelect),
    .globalEna(enaBits[0]), .regionalEna(enaBits[1]), .extEna(enaBits[2]),
    .extCoreData(extCoreData), .globalNet(globalNet), .regionalNet(regionalNet),
    .extPllClkPin(extPllClkPin), .userMode(userMode));

  assign probe = (probeSel == 2'h0) ? globalNet : (probeSel == 2'h1) ? regionalNet : extPllClkPin;

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Expected period of a source input
  function automatic logic [7:0] srcPer(input int n);
    int half;
    case (n)
      0: half = cfgPinPickA + 3;
      1: half = cfgPinPickB + 3;
      2: half = cfgPllEven * 7 + (cfgCntEven ? 2 : 0) + 7;
      default: half = cfgPllOdd * 7 + (cfgCntOdd ? 3 : 1) + 7;
    endcase
    return 8'(2 * half);
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (failures == 0 && checkCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic waitLevel(input logic lvl, output logic [7:0] n);
    n = 8'h00;
    while (probe !== lvl && n < 8'hfa)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // Period and high width of one output
  task automatic measure(input logic [1:0] p, input logic [7:0] expPer);
    logic [7:0] n;
    logic [7:0] high;
    probeSel = p;
    waitLevel(1'b0, n);
    waitLevel(1'b1, n);
    waitLevel(1'b0, high);
    waitLevel(1'b1, n);
    check(high + n, expPer);
    check(high, expPer >> 1);
  endtask

  task automatic countEdges(input logic [1:0] p);
    logic prev;
    probeSel = p;
    edges = 8'h00;
    prev = probe;
    repeat (100)
    begin
      @(posedge clk);
      #1;
      if (probe === 1'b1 && prev !== 1'b1)
        edges++;
      prev = probe;
    end
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      print_verdict;
    end
  end

  initial
  begin
    failures = 0;
    checkCount = 0;
    cycles = 0;
    probeSel = 2'h0;
    reset_n = 1'b0;
    userModePin = 1'b0;
    cfgPinPickA = 2'h2;
    cfgPinPickB = 2'h1;
    cfgPllEven = 1'b1;
    cfgCntEven = 1'b1;
    cfgPllOdd = 1'b0;
    cfgCntOdd = 1'b1;
    cfgGlobalOff = 1'b0;
    cfgGlobalBypass = 1'b0;
    cfgRegionalSel = 2'h2;
    cfgRegionalOff = 1'b0;
    cfgRegionalBypass = 1'b1;
    cfgExtOff = 1'b0;
    cfgExtSel = 2'h3;
    cfgExtDrive = 1'b0;
    extCoreData = 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    measure(2'h0, srcPer(0));
    measure(2'h1, srcPer(2));
    @(posedge clk);
    extCoreData <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check({7'h00, extPllClkPin}, 8'h01);
    @(posedge clk);
    cfgExtDrive <= 1'b1;
    measure(2'h2, srcPer(3));
    @(posedge clk);
    userModePin <= 1'b1;
    repeat (10) @(posedge clk);
    #1 check({7'h00, userMode}, 8'h01);
    @(posedge clk);
    cfgExtDrive <= 1'b0;
    cfgRegionalSel <= 2'h0;
    measure(2'h2, srcPer(3));
    measure(2'h1, srcPer(2));
    for (int s = 0; s < 4; s++)
    begin
      cnc_core_model_i.drive(2'(s), 3'h7);
      repeat (150) @(posedge clk);
      measure(2'h0, srcPer(s));
    end
    for (int p = 0; p < 3; p++)
    begin
      ena = 3'h7;
      ena[p] = 1'b0;
      cnc_core_model_i.drive(2'h3, ena);
      repeat (30) @(posedge clk);
      countEdges(2'(p));
      check(edges, 8'h00);
      cnc_core_model_i.drive(2'h3, 3'h7);
      measure(2'(p), (p == 1) ? srcPer(2) : srcPer(3));
    end
    @(posedge clk);
    reset_n <= 1'b0;
    userModePin <= 1'b0;
    cfgGlobalOff <= 1'b1;
    cfgRegionalOff <= 1'b1;
    cfgGlobalBypass <= 1'b1;
    cfgPinPickA <= 2'h0;
    cfgPllEven <= 1'b0;
    cfgCntEven <= 1'b0;
    repeat (10) @(posedge clk);
    #1 check({7'h00, userMode}, 8'h00);
    @(posedge clk);
    reset_n <= 1'b1;
    countEdges(2'h0);
    check(edges, 8'h00);
    countEdges(2'h1);
    check(edges, 8'h00);
    @(posedge clk);
    cfgGlobalOff <= 1'b0;
    repeat (3) @(posedge clk);
    userModePin <= 1'b1;
    repeat (10) @(posedge clk);
    cnc_core_model_i.drive(2'h2, 3'h7);
    repeat (150) @(posedge clk);
    measure(2'h0, srcPer(2));
    cnc_core_model_i.drive(2'h0, 3'h7);
    repeat (150) @(posedge clk);
    measure(2'h0, srcPer(0));
    print_verdict;
  end
endmodule

`default_nettype wire

// ===== sim/cnc_core_model.sv
`timescale 1ns/10ps
`default_nettype none

module cnc_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Source clocks
  output logic [3:0] pinClk,
  output logic [13:0] pllCnt,
  // Core controls
  output cnc_pkg::cnc_sel_t sourceSelect,
  output logic [2:0] enaBits
);
  import cnc_pkg::*;
  logic [17:0] srcR = '0;
  logic [7:0] tick [18] = '{default: 8'h00};

  // Free-running sources, half period index plus three
  always @(posedge clk)
  begin
    for (int i = 0; i < 18; i++)
    begin
      if (tick[i] == 8'(i + 2))
      begin
        tick[i] <= 8'h00;
        srcR[i] <= ~srcR[i];
      end
      else
        tick[i] <= tick[i] + 8'h01;
    end
  end

  assign pinClk = srcR[3:0];
  assign pllCnt = srcR[17:4];

  initial
  begin
    sourceSelect = 2'h3;
    enaBits = 3'h7;
  end

  // Core select and enables change just after an edge
  task automatic drive(input cnc_sel_t s, input logic [2:0] e);
    @(posedge clk);
    sourceSelect <= s;
    enaBits <= e;
  endtask
endmodule

`default_nettype wire
